//--- src/pdtmc_top.sv
// port disconnect timers, general configuration register and event gating
// assumes the bus front end hands over decoded command codes as one-cycle strobes
//
// Function
// RQ1: with disconnect detection enabled, power a port off after the disconnect timeout.
// RQ2: clear the disconnect counter after 15 ms of continuous current above threshold.
// RQ3: the disconnect counter saturates at zero, never counting below.
// RQ4: timeout select 00=360 ms, 01=90 ms, 10=180 ms, 11=720 ms.
// RQ5: general configuration is command 17h, one byte, readable and writable.
// RQ6: master enable low keeps the interrupt pin inactive; events untouched.
// RQ7: access width 1 gives 16-bit single address; 0 gives two 8-bit devices.
// RQ8: class change only raises the class flag just when the class differs.
// RQ9: detect change only raises the detect flag just when detection differs.
// RQ10: count while a powered port is below threshold; reaching timeout turns it off.
`timescale 1ns/1ps
`default_nettype none
module pdtmc_top #(
  parameter logic [pdtmc_pkg::CNT_W-1:0] P_DISC_CYC_00 = pdtmc_pkg::CNT_W'(pdtmc_pkg::CYC_DISC_SEL00),
  parameter logic [pdtmc_pkg::CNT_W-1:0] P_DISC_CYC_01 = pdtmc_pkg::CNT_W'(pdtmc_pkg::CYC_DISC_SEL01),
  parameter logic [pdtmc_pkg::CNT_W-1:0] P_DISC_CYC_10 = pdtmc_pkg::CNT_W'(pdtmc_pkg::CYC_DISC_SEL10),
  parameter logic [pdtmc_pkg::CNT_W-1:0] P_DISC_CYC_11 = pdtmc_pkg::CNT_W'(pdtmc_pkg::CYC_DISC_SEL11),
  parameter logic [pdtmc_pkg::CLR_W-1:0] P_CLEAR_CYC   = pdtmc_pkg::CLR_W'(pdtmc_pkg::CYC_CLEAR)
) (
  // clock and reset
  input  wire logic                                   I_MCLK,
  input  wire logic                                   I_RST_N,
  // command port
  input  wire pdtmc_pkg::pdtmc_cmd_t                  I_CMD,
  output logic [7:0]                                  O_RD_DATA,
  output logic                                        O_RD_VALID,
  // port power state
  input  wire logic [pdtmc_pkg::NUM_PORTS-1:0]        I_DISC_EN,
  input  wire logic [pdtmc_pkg::NUM_PORTS-1:0]        I_PORT_ON,
  input  wire logic [pdtmc_pkg::NUM_PORTS-1:0]        I_BELOW_DISC,
  output logic      [pdtmc_pkg::NUM_PORTS-1:0]        O_PORT_OFF_REQ,
  // detection and classification results
  input  wire logic [pdtmc_pkg::NUM_PORTS-1:0]        I_DET_DONE,
  input  wire logic [pdtmc_pkg::NUM_PORTS*pdtmc_pkg::DET_RES_W-1:0] I_DET_RESULT,
  input  wire logic [pdtmc_pkg::NUM_PORTS-1:0]        I_CLS_DONE,
  input  wire logic [pdtmc_pkg::NUM_PORTS*pdtmc_pkg::CLS_RES_W-1:0] I_CLS_RESULT,
  output logic      [pdtmc_pkg::NUM_PORTS-1:0]        O_DETECT_EVENT_FLAG,
  output logic      [pdtmc_pkg::NUM_PORTS-1:0]        O_CLASS_EVENT_FLAG,
  // interrupt
  input  wire logic                                   I_IRQ_PENDING,
  output logic                                        O_INT_N,
  // configuration outputs
  output logic                                        O_ACCESS_WIDE,
  output logic                                        O_MULTI_LEVEL_PRIO,
  output logic [1:0]                                  O_OVERCURRENT_TIMEOUT_SEL
);
  import pdtmc_pkg::*;

  pdtmc_gcfg_t      gcfg_r;
  logic [3:0]       tcfg_r;
  logic [1:0]       disconnect_timeout_sel;
  logic [CNT_W-1:0] disc_limit;
  logic [7:0]       rd_nxt;

  assign disconnect_timeout_sel = tcfg_r[FLD_DISC_SEL_LSB +: 2];

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      gcfg_r <= pdtmc_gcfg_t'(GCFG_RESET);
    end else if (I_CMD.wr && I_CMD.code == CMD_GENERAL_CFG) begin
      gcfg_r <= pdtmc_gcfg_t'(I_CMD.data); // [RQ5]
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      tcfg_r <= TCFG_RESET;
    end else if (I_CMD.wr && I_CMD.code == CMD_TIMING_CFG) begin
      tcfg_r <= I_CMD.data[3:0];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    rd_nxt = 8'h00;
    if (I_CMD.code == CMD_GENERAL_CFG) begin
      rd_nxt = gcfg_r; // [RQ5]
    end else if (I_CMD.code == CMD_TIMING_CFG) begin
      rd_nxt = {4'h0, tcfg_r};
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_RD_DATA  <= 8'h00;
      O_RD_VALID <= 1'b0;
    end else begin
      O_RD_VALID <= I_CMD.rd;
      O_RD_DATA  <= I_CMD.rd ? rd_nxt : 8'h00;
    end
  end

  // ****************************************************************
  // interrupt pin and configuration outputs
  // ****************************************************************
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_INT_N                   <= 1'b1;
      O_ACCESS_WIDE             <= 1'b0;
      O_MULTI_LEVEL_PRIO        <= 1'b0;
      O_OVERCURRENT_TIMEOUT_SEL <= 2'h0;
    end else begin
      O_INT_N                   <= !(I_IRQ_PENDING && gcfg_r.irq_pin_master_enable); // [RQ6]
      O_ACCESS_WIDE             <= gcfg_r.access_width_sel; // [RQ7]
      O_MULTI_LEVEL_PRIO        <= gcfg_r.multi_level_priority_sel;
      O_OVERCURRENT_TIMEOUT_SEL <= tcfg_r[FLD_OVC_SEL_LSB +: 2];
    end
  end

  // ****************************************************************
  // disconnect timeout selection
  // ****************************************************************
  always_comb begin
    unique case (disconnect_timeout_sel) // [RQ4]
      DISC_SEL_360: disc_limit = P_DISC_CYC_00;
      DISC_SEL_90:  disc_limit = P_DISC_CYC_01;
      DISC_SEL_180: disc_limit = P_DISC_CYC_10;
      DISC_SEL_720: disc_limit = P_DISC_CYC_11;
    endcase
  end

  // ****************************************************************
  // per-port timers and event gating
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      logic [DET_RES_W-1:0] det_prev_r;
      logic [CLS_RES_W-1:0] cls_prev_r;
      logic [DET_RES_W-1:0] det_res;
      logic [CLS_RES_W-1:0] cls_res;

      assign det_res = I_DET_RESULT[gi*DET_RES_W +: DET_RES_W];
      assign cls_res = I_CLS_RESULT[gi*CLS_RES_W +: CLS_RES_W];

      pdtmc_port_timer u_timer (
        .i_mclk      (I_MCLK),
        .i_rst_n     (I_RST_N),
        .i_disc_en   (I_DISC_EN[gi]),
        .i_powered   (I_PORT_ON[gi]),
        .i_below     (I_BELOW_DISC[gi]),
        .i_limit     (disc_limit),
        .i_clear_cyc (P_CLEAR_CYC),
        .o_off_req   (O_PORT_OFF_REQ[gi])
      );

      always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
          det_prev_r             <= '0;
          O_DETECT_EVENT_FLAG[gi] <= 1'b0;
        end else begin
          O_DETECT_EVENT_FLAG[gi] <= I_DET_DONE[gi] &&
                                     (!gcfg_r.detect_change_only || det_res != det_prev_r); // [RQ9]
          if (I_DET_DONE[gi]) begin
            det_prev_r <= det_res;
          end
        end
      end

      always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
          cls_prev_r            <= '0;
          O_CLASS_EVENT_FLAG[gi] <= 1'b0;
        end else begin
          O_CLASS_EVENT_FLAG[gi] <= I_CLS_DONE[gi] &&
                                    (!gcfg_r.class_change_only || cls_res != cls_prev_r); // [RQ8]
          if (I_CLS_DONE[gi]) begin
            cls_prev_r <= cls_res;
          end
        end
      end

      det_same_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // [RQ9]
        (I_DET_DONE[gi] && gcfg_r.detect_change_only && det_res == det_prev_r) |=> !O_DETECT_EVENT_FLAG[gi])
        else $error("detect flag raised without a change");

      cls_every_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // [RQ8]
        (I_CLS_DONE[gi] && !gcfg_r.class_change_only) |=> O_CLASS_EVENT_FLAG[gi])
        else $error("class flag missing after a classification");

      det_every_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // [RQ9]
        (I_DET_DONE[gi] && !gcfg_r.detect_change_only) |=> O_DETECT_EVENT_FLAG[gi])
        else $error("detect flag missing after a detection");

      cls_same_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // [RQ8]
        (I_CLS_DONE[gi] && gcfg_r.class_change_only && cls_res == cls_prev_r) |=> !O_CLASS_EVENT_FLAG[gi])
        else $error("class flag raised without a change");

      port_idle_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // [RQ10]
        !(I_DISC_EN[gi] && I_PORT_ON[gi]) |=> !O_PORT_OFF_REQ[gi])
        else $error("off request from a port that is not counting");
    end
  endgenerate

  // ****************************************************************
  // checks
  // ****************************************************************
  irq_gate_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // [RQ6]
    !gcfg_r.irq_pin_master_enable |=> O_INT_N)
    else $error("interrupt pin active with master enable low");

  irq_follow_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // [RQ6]
    (gcfg_r.irq_pin_master_enable && I_IRQ_PENDING) |=> !O_INT_N)
    else $error("interrupt pin not driven with master enable high");

  rd_answer_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // [RQ5]
    I_CMD.rd |=> O_RD_VALID)
    else $error("read strobe not answered in the next cycle");

  cfg_rw_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // [RQ5]
    (I_CMD.wr && !I_CMD.rd && I_CMD.code == CMD_GENERAL_CFG) ##1 !I_CMD.wr ##1
    (I_CMD.rd && !I_CMD.wr && I_CMD.code == CMD_GENERAL_CFG) |=> O_RD_VALID && O_RD_DATA == $past(I_CMD.data, 3))
    else $error("general configuration read back differs from write");

  access_width_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // [RQ7]
    (I_CMD.wr && I_CMD.code == CMD_GENERAL_CFG) |=> ##1 O_ACCESS_WIDE == $past(I_CMD.data[5], 2))
    else $error("access width output does not follow the configuration");

  limit_select_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_N) // [RQ4]
    (I_CMD.wr && I_CMD.code == CMD_TIMING_CFG && I_CMD.data[FLD_DISC_SEL_LSB +: 2] == DISC_SEL_90)
    |=> disc_limit == P_DISC_CYC_01)
    else $error("wrong disconnect timeout for select 01");

endmodule
`default_nettype wire

//--- src/pdtmc_pkg.sv
// package of constants and types for the port disconnect timer and general configuration block
// assumes a 200 MHz core clock and a byte-wide command port decoded by the host bus front end
`default_nettype none
package pdtmc_pkg;

  localparam int unsigned NUM_PORTS   = 8;
  localparam int unsigned DET_RES_W   = 4;
  localparam int unsigned CLS_RES_W   = 3;
  localparam int unsigned CNT_W       = 28;
  localparam int unsigned CLR_W       = 22;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] CMD_TIMING_CFG  = 8'h16;
  localparam logic [7:0] CMD_GENERAL_CFG = 8'h17;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int unsigned FLD_DISC_SEL_LSB = 0;
  localparam int unsigned FLD_OVC_SEL_LSB  = 2;
  localparam logic [7:0]  GCFG_RESET       = 8'h80;
  localparam logic [3:0]  TCFG_RESET       = 4'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_KHZ          = 200000;
  localparam int unsigned T_DISC_SEL00_MS  = 360;
  localparam int unsigned T_DISC_SEL01_MS  = 90;
  localparam int unsigned T_DISC_SEL10_MS  = 180;
  localparam int unsigned T_DISC_SEL11_MS  = 720;
  localparam int unsigned T_CLEAR_MS       = 15;
  localparam int unsigned CYC_DISC_SEL00   = T_DISC_SEL00_MS * CLK_KHZ;
  localparam int unsigned CYC_DISC_SEL01   = T_DISC_SEL01_MS * CLK_KHZ;
  localparam int unsigned CYC_DISC_SEL10   = T_DISC_SEL10_MS * CLK_KHZ;
  localparam int unsigned CYC_DISC_SEL11   = T_DISC_SEL11_MS * CLK_KHZ;
  localparam int unsigned CYC_CLEAR        = T_CLEAR_MS * CLK_KHZ;

  localparam logic [1:0] DISC_SEL_360 = 2'h0;
  localparam logic [1:0] DISC_SEL_90  = 2'h1;
  localparam logic [1:0] DISC_SEL_180 = 2'h2;
  localparam logic [1:0] DISC_SEL_720 = 2'h3;

  // general configuration byte, bit 7 down to bit 0
  typedef struct packed {
    logic       irq_pin_master_enable;
    logic       rsv6;
    logic       access_width_sel;
    logic       multi_level_priority_sel;
    logic       class_change_only;
    logic       detect_change_only;
    logic [1:0] rsv10;
  } pdtmc_gcfg_t;

  // command port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] code;
    logic [7:0] data;
  } pdtmc_cmd_t;

endpackage
`default_nettype wire

//--- src/pdtmc_port_timer.sv
// one port's disconnect timer: counts low-current time, saturating at zero
// assumes the limit and clear window are stable cycle counts from the top
`timescale 1ns/1ps
`default_nettype none
module pdtmc_port_timer (
  // clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst_n,
  // port state
  input  wire logic                      i_disc_en,
  input  wire logic                      i_powered,
  input  wire logic                      i_below,
  // timing
  input  wire logic [pdtmc_pkg::CNT_W-1:0] i_limit,
  input  wire logic [pdtmc_pkg::CLR_W-1:0] i_clear_cyc,
  // result
  output logic                           o_off_req
);
  import pdtmc_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CLR_W-1:0] above_r;
  logic             active;
  logic             clear_hit;

  assign active    = i_disc_en && i_powered;
  assign clear_hit = active && !i_below && (above_r == i_clear_cyc - 1'b1);

  // ****************************************************************
  // continuous above-threshold window
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !active || i_below || clear_hit) begin
      above_r <= '0;
    end else begin
      above_r <= above_r + 1'b1;
    end
  end

  // ****************************************************************
  // disconnect counter
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !active) begin
      cnt_r     <= '0;
      o_off_req <= 1'b0;
    end else if (i_below) begin
      if (cnt_r >= i_limit - 1'b1) begin // [RQ1] [RQ10]
        cnt_r     <= '0;
        o_off_req <= 1'b1;
      end else begin
        cnt_r     <= cnt_r + 1'b1; // [RQ10]
        o_off_req <= 1'b0;
      end
    end else begin
      o_off_req <= 1'b0;
      if (clear_hit) begin
        cnt_r <= '0; // [RQ2]
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1; // [RQ3]
      end
    end
  end

  no_wrap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ3]
    ($past(cnt_r) == '0 && !$past(i_below)) |-> cnt_r == '0)
    else $error("disconnect counter went below zero");

  off_cause_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ1]
    o_off_req |-> $past(active) && $past(i_below) && $past(cnt_r) >= $past(i_limit) - 1'b1)
    else $error("port off request without a full disconnect time");

  clear_window_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // [RQ2]
    clear_hit |=> cnt_r == '0)
    else $error("counter not cleared after the above-threshold window");

endmodule
`default_nettype wire

//--- bench/pdtmc_host_model.sv
// host side model: issues command port writes and reads
// assumes the command port of pdtmc_top and a free running core clock
`timescale 1ns/1ps
`default_nettype none
module pdtmc_host_model (
  // clock
  input  wire logic                 i_mclk,
  // command port
  output var pdtmc_pkg::pdtmc_cmd_t o_cmd,
  input  wire logic [7:0]           i_rd_data,
  input  wire logic                 i_rd_valid
);
  import pdtmc_pkg::*;
  initial o_cmd = '0;
  // one byte write, strobe held for one edge
  task automatic write_reg(input logic [7:0] code, input logic [7:0] data);
    @(negedge i_mclk);
    o_cmd = {2'b10, code, data};
    @(negedge i_mclk);
    o_cmd = {2'b00, ~code, ~data};
  endtask
  // one byte read, answer taken while the valid pulse stands
  task automatic read_reg(input logic [7:0] code, output logic [7:0] data);
    int k;
    @(negedge i_mclk);
    o_cmd = {2'b01, code, 8'h00};
    @(negedge i_mclk);
    o_cmd = {2'b00, ~code, 8'hFF};
    k = 0;
    while (i_rd_valid !== 1'b1 && k < 4) begin
      @(negedge i_mclk);
      k++;
    end
    data = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
  endtask
endmodule
`default_nettype wire

//--- bench/pdtmc_top_test.sv
// self-checking bench for the disconnect timers and general configuration
// assumes shortened timer parameters 40/10/20/80 and clear window 6
`timescale 1ns/1ps
`default_nettype none
module pdtmc_top_test;
  import pdtmc_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  pdtmc_cmd_t  cmd;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic [7:0]  en = 8'h01;
  logic [7:0]  on = 8'h01;
  logic [7:0]  below = 8'h00;
  logic [7:0]  off_req;
  logic [7:0]  det_done = 8'h00;
  logic [7:0]  cls_done = 8'h00;
  logic [31:0] det_res = '0;
  logic [23:0] cls_res = '0;
  logic [7:0]  det_flag;
  logic [7:0]  cls_flag;
  logic        pend = 1'b0;
  logic        int_n;
  logic        wide;
  logic        mprio;
  logic [1:0]  ovc_sel;
  logic [15:0] seed = 16'h23E9;
  logic [7:0]  d;
  logic [3:0]  pd [8];
  logic [2:0]  pc [8];
  int          lim [4] = '{40, 10, 20, 80};
  int          errors = 0;
  int          compares = 0;
  always #2.5 mclk = ~mclk;
  pdtmc_host_model pdtmc_host_model_inst (.i_mclk(mclk), .o_cmd(cmd), .i_rd_data(rd_data), .i_rd_valid(rd_valid));
  pdtmc_top #(.P_DISC_CYC_00(28'h28), .P_DISC_CYC_01(28'h0A), .P_DISC_CYC_10(28'h14),
    .P_DISC_CYC_11(28'h50), .P_CLEAR_CYC(22'h6)) pdtmc_top_inst (
    .I_MCLK(mclk), .I_RST_N(rst_n), .I_CMD(cmd), .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid),
    .I_DISC_EN(en), .I_PORT_ON(on), .I_BELOW_DISC(below), .O_PORT_OFF_REQ(off_req),
    .I_DET_DONE(det_done), .I_DET_RESULT(det_res), .I_CLS_DONE(cls_done), .I_CLS_RESULT(cls_res),
    .O_DETECT_EVENT_FLAG(det_flag), .O_CLASS_EVENT_FLAG(cls_flag), .I_IRQ_PENDING(pend),
    .O_INT_N(int_n), .O_ACCESS_WIDE(wide), .O_MULTI_LEVEL_PRIO(mprio), .O_OVERCURRENT_TIMEOUT_SEL(ovc_sel));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask
  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // below for pre cycles, above for up cycles, then count cycles to the off pulse
  task automatic tmr(input logic [1:0] sel, input int pre, input int up, output int k);
    pdtmc_host_model_inst.write_reg(CMD_TIMING_CFG, {6'h00, sel});
    if (pre > 0) begin
      below = 8'h01;
      repeat (pre) @(negedge mclk);
    end
    if (up > 0) begin
      below = 8'h00;
      repeat (up) @(negedge mclk);
    end
    below = 8'h01;
    k = 0;
    while (off_req[0] !== 1'b1 && k < 200) begin
      @(negedge mclk);
      k++;
    end
    below = 8'h00;
    repeat (8) @(negedge mclk);
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    int k;
    logic [7:0] acc;
    for (int p = 0; p < 8; p++) begin
      pd[p] = 4'h0;
      pc[p] = 3'h0;
    end
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    pdtmc_host_model_inst.read_reg(CMD_GENERAL_CFG, d);
    chk(d, GCFG_RESET);
    chk_bit(wide, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? 8'h20 : seed[7:0];
      pdtmc_host_model_inst.write_reg(CMD_GENERAL_CFG, d);
      pdtmc_host_model_inst.read_reg(CMD_GENERAL_CFG, acc);
      chk(acc, d);
      chk_bit(wide, d[5]);
      chk_bit(mprio, d[4]);
    end
    pdtmc_host_model_inst.read_reg(8'h33, acc);
    chk(acc, 8'h00);
    seed = lfsr(seed);
    pdtmc_host_model_inst.write_reg(CMD_TIMING_CFG, seed[7:0]);
    pdtmc_host_model_inst.read_reg(CMD_TIMING_CFG, acc);
    chk(acc, {4'h0, seed[3:0]});
    chk(ovc_sel, seed[3:2]);
    $display("test register done");
    pend = 1'b1;
    pdtmc_host_model_inst.write_reg(CMD_GENERAL_CFG, 8'h80);
    repeat (2) @(negedge mclk);
    chk_bit(int_n, 1'b0);
    pdtmc_host_model_inst.write_reg(CMD_GENERAL_CFG, 8'h00);
    repeat (2) @(negedge mclk);
    chk_bit(int_n, 1'b1);
    pend = 1'b0;
    $display("test interrupt done");
    for (int s = 0; s < 4; s++) begin
      tmr(s[1:0], 0, 0, k);
      chk_cnt(k, lim[s]);
    end
    tmr(2'h0, 30, 6, k);
    chk_cnt(k, 40);
    tmr(2'h0, 3, 5, k);
    chk_cnt(k, 40);
    tmr(2'h0, 5, 2, k);
    chk_cnt(k, 37);
    en = 8'h0F;
    on = 8'hF0;
    below = 8'hFF;
    acc = 8'h00;
    repeat (100) begin
      @(negedge mclk);
      acc = acc | off_req;
    end
    chk(acc, 8'h00);
    below = 8'h00;
    en = 8'h01;
    on = 8'h01;
    $display("test timer done");
    for (int m = 0; m < 4; m++) begin
      pdtmc_host_model_inst.write_reg(CMD_GENERAL_CFG, {m[0], 3'h0, m[1:0], 2'b00});
      repeat (12) begin
        seed = lfsr(seed);
        det_res = {seed, seed} & 32'h1111_1111;
        cls_res = {seed[11:0], seed[15:4]} & 24'h249249;
        det_done = seed[7:0];
        cls_done = seed[15:8];
        @(negedge mclk);
        for (int p = 0; p < 8; p++) begin
          chk_bit(det_flag[p], seed[p] && (!m[0] || det_res[4*p+:4] != pd[p]));
          chk_bit(cls_flag[p], seed[p+8] && (!m[1] || cls_res[3*p+:3] != pc[p]));
          if (seed[p]) pd[p] = det_res[4*p+:4];
          if (seed[p+8]) pc[p] = cls_res[3*p+:3];
        end
      end
      det_done = 8'h00;
      cls_done = 8'h00;
    end
    $display("test events done");
    complete_run();
  end
  initial begin
    #100000;
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
